//--- dv/testbench.sv
// self-checking bench for the panel control block with a sequencer stand-in
// assumes a 100 MHz clock and a two-hand pairing window shortened to 20 cycles
`timescale 1ns/1ps
module testbench;
  logic        clk, reset_n, seq_error, reg_wr, reg_rd;
  logic [13:0] pins;
  logic [7:0]  reg_addr, cyc_len;
  logic [31:0] reg_wdata, reg_rdata, rdv;
  logic [8:0]  cyc_programming_position, seq_programming_position, last_programming_position;
  logic [1:0]  cyc_tool, seq_tool;
  logic [63:0] cyc_id, seq_programming_position_id;
  logic        seq_cycle_done, seq_inv_cmd, start_req, inv_cmd_out, aux_supply_output, cap_charge_out;
  logic        keypad_en, led_dual_button_start, led_weld, led_start1, led_start2, led_press_stop;
  logic        led_inv, status_update, weld, rst_done;
  logic [3:0]  seq_valve, valve_out, led_valve;
  logic [15:0] exp_cnt [4];
  logic [2:0]  tools_en;
  int          mismatches, check_count, starts, dones, upds;

  wpc_panel_ctrl #(.HAND_WIN(20)) u_wpc_panel_ctrl (.clk, .reset_n, .pins_in(pins), .seq_cycle_done,
    .seq_programming_position, .seq_tool, .seq_programming_position_id, .seq_error, .seq_inv_cmd, .seq_valve, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .start_req, .inv_cmd_out, .valve_out, .aux_supply_output,
    .cap_charge_out, .keypad_en, .led_dual_button_start, .led_weld, .led_start1, .led_start2,
    .led_press_stop, .led_inv, .led_valve, .status_update);
  wpc_seq_model u_wpc_seq_model (.clk, .reset_n, .start_req, .cyc_len, .cyc_programming_position, .cyc_tool, .cyc_id,
    .seq_cycle_done, .seq_programming_position, .seq_tool, .seq_programming_position_id, .seq_inv_cmd, .seq_valve);

  // clock
  always #5 clk = ~clk;

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // register port: one-cycle strobes, read data sampled in the following cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
  endtask

  // key press long enough to pass the pin filter, then release
  task automatic press(input int b);
    @(posedge clk);
    pins[b] <= 1'b1;
    repeat (8) @(posedge clk);
    pins[b] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic pair(input int gap);
    @(posedge clk);
    pins[10] <= 1'b1;
    repeat (gap) @(posedge clk);
    pins[11] <= 1'b1;
    repeat (8) @(posedge clk);
    pins[11:10] <= 2'b00;
    repeat (8) @(posedge clk);
  endtask

  task automatic chkcnt();
    for (int i = 0; i < 4; i++) begin
      rd(wpc_pkg::REG_COUNT0 + 8'(4 * i));
      chk("spot counter", {16'h0000, exp_cnt[i]}, rdv);
    end
  endtask

  // one start attempt with random cycle data; expectations follow mode and tool count
  task automatic cyc(input bit hand, input int gap, input bit go);
    int s0;
    int d0;
    logic [1:0] t;
    s0 = starts;
    d0 = dones;
    t = 2'($urandom_range(0, 3));
    cyc_len <= 8'($urandom_range(2, 20));
    cyc_tool <= t;
    cyc_programming_position <= 9'($urandom_range(0, 300));
    cyc_id <= {$urandom, $urandom};
    if (hand) pair(gap);
    else press(wpc_pkg::PIN_PEDAL);
    for (int i = 0; i < 60 && dones == d0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk("start count", go, starts - s0);
    if (go) begin
      if (weld && t < tools_en && exp_cnt[t] < wpc_pkg::SPOT_MAX) exp_cnt[t]++;
      if (cyc_programming_position >= wpc_pkg::PROGRAMMING_POSITION_MIN && cyc_programming_position <= wpc_pkg::PROGRAMMING_POSITION_MAX) last_programming_position = cyc_programming_position;
      rd(wpc_pkg::REG_LAST);
      chk("last program", last_programming_position, rdv[8:0]);
      chk("last tool", t, rdv[10:9]);
      chk("tool four flag", (t == 2'h3), rdv[11]);
      rd(wpc_pkg::REG_ID_LO);
      chk("id low", cyc_id[31:0], rdv);
      rd(wpc_pkg::REG_ID_HI);
      chk("id high", cyc_id[63:32], rdv);
    end
  endtask

  // event counters and per-cycle output mirrors
  always @(posedge clk) begin
    if (start_req === 1'b1) starts++;
    if (seq_cycle_done === 1'b1) dones++;
    if (status_update === 1'b1) upds++;
  end

  always @(negedge clk) begin
    if (reset_n === 1'b1) begin
      chk("led_inv", inv_cmd_out, led_inv);
      chk("led_valve", valve_out, led_valve);
      chk("valve_out", seq_valve & {4{rst_done}}, valve_out);
      chk("inv_cmd_out", seq_inv_cmd & rst_done & weld, inv_cmd_out);
    end
  end

  // watchdog
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    $display("unexpected watchdog expiry");
    conclude();
  end

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    pins = '0;
    {seq_error, reg_wr, reg_rd, weld, rst_done} = '0;
    {reg_addr, reg_wdata, cyc_len, cyc_programming_position, cyc_tool, cyc_id, last_programming_position} = '0;
    tools_en = 3'h4;
    for (int i = 0; i < 4; i++) exp_cnt[i] = 16'h0000;
    void'($urandom(32'h6b94bec0));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd(wpc_pkg::REG_CFG);
    chk("cfg reset", 4, rdv);
    cyc(0, 1, 0);
    press(wpc_pkg::PIN_WELD_KEY);
    chk("aux before restart", 0, aux_supply_output);
    press(wpc_pkg::PIN_RESTART);
    rst_done = 1'b1;
    chk("aux", 1, aux_supply_output);
    chk("cap charge", 1, cap_charge_out);
    chk("led_weld", 0, led_weld);
    cyc(0, 1, 1);
    chkcnt();
    press(wpc_pkg::PIN_WELD_KEY);
    weld = 1'b1;
    chk("led_weld", 1, led_weld);
    repeat (10) cyc(0, 1, 1);
    chkcnt();
    // programming position: indicators follow pins, starts blocked
    pins[wpc_pkg::PIN_PROGRAMMING_POSITION] <= 1'b1;
    repeat (6) @(posedge clk);
    chk("keypad_en", 1, keypad_en);
    for (int k = 0; k < 16; k++) begin
      pins[13:10] <= 4'(k);
      repeat (6) @(posedge clk);
      chk("led_start1", k[0], led_start1);
      chk("led_start2", k[1], led_start2);
      chk("led_press_stop", k[3] & k[2], led_press_stop);
    end
    pins[13:10] <= 4'h0;
    cyc(0, 1, 0);
    pins[wpc_pkg::PIN_PROGRAMMING_POSITION] <= 1'b0;
    repeat (6) @(posedge clk);
    chk("keypad_en", 0, keypad_en);
    // start source selection and two-hand pairing
    press(wpc_pkg::PIN_SRC_KEY);
    chk("led_dual_button_start", 1, led_dual_button_start);
    cyc(0, 1, 0);
    cyc(1, 1, 1);
    cyc(1, 12, 1);
    cyc(1, 35, 0);
    press(wpc_pkg::PIN_SRC_KEY);
    chk("led_dual_button_start", 0, led_dual_button_start);
    cyc(1, 1, 0);
    // latched error blocks starts until the clear key
    @(posedge clk);
    seq_error <= 1'b1;
    @(posedge clk);
    seq_error <= 1'b0;
    rd(wpc_pkg::REG_STATUS);
    chk("error latch", 1, rdv[5]);
    cyc(0, 1, 0);
    press(wpc_pkg::PIN_CLEAR);
    rd(wpc_pkg::REG_STATUS);
    chk("menu and error", 2'b10, rdv[6:5]);
    press(wpc_pkg::PIN_UP);
    rd(wpc_pkg::REG_STATUS);
    chk("clear target", 1, rdv[9:7]);
    press(wpc_pkg::PIN_PLUS);
    exp_cnt[1] = 16'h0000;
    chkcnt();
    press(wpc_pkg::PIN_CLEAR);
    repeat (4) press(wpc_pkg::PIN_UP);
    rd(wpc_pkg::REG_STATUS);
    chk("clear target", wpc_pkg::TGT_ALL, rdv[9:7]);
    press(wpc_pkg::PIN_DOWN);
    rd(wpc_pkg::REG_STATUS);
    chk("clear target", 3, rdv[9:7]);
    press(wpc_pkg::PIN_MINUS);
    chkcnt();
    press(wpc_pkg::PIN_CLEAR);
    repeat (4) press(wpc_pkg::PIN_UP);
    press(wpc_pkg::PIN_PLUS);
    for (int i = 0; i < 4; i++) exp_cnt[i] = 16'h0000;
    chkcnt();
    // two tools enabled: other tools no longer count
    wr(wpc_pkg::REG_CFG, 32'h0000_0002);
    wr(wpc_pkg::REG_CFG, 32'h0000_0005);
    rd(wpc_pkg::REG_CFG);
    chk("cfg", 2, rdv[2:0]);
    tools_en = 3'h2;
    repeat (8) cyc(0, 1, 1);
    chkcnt();
    rd(8'h40);
    chk("unmapped read", 0, rdv);
    chk("status updates", dones, upds);
    conclude();
  end
endmodule

//--- dv/wpc_seq_model.sv
// stand-in for the welding cycle sequencer on the far side of the panel block
// assumes the bench sets length, program, tool and identifier before each start
`timescale 1ns/1ps
module wpc_seq_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        start_req,
  input  wire logic [7:0]  cyc_len,
  input  wire logic [8:0]  cyc_programming_position,
  input  wire logic [1:0]  cyc_tool,
  input  wire logic [63:0] cyc_id,
  output logic             seq_cycle_done,
  output logic [8:0]       seq_programming_position,
  output logic [1:0]       seq_tool,
  output logic [63:0]      seq_programming_position_id,
  output logic             seq_inv_cmd,
  output logic [3:0]       seq_valve
);
  logic [7:0] left_ff;
  // cycle timer: a start loads the length, done pulses on the last tick
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      left_ff        <= 8'h00;
      seq_cycle_done <= 1'b0;
    end else if (left_ff == 8'h00) begin
      seq_cycle_done <= 1'b0;
      if (start_req) begin
        left_ff <= cyc_len;
      end
    end else begin
      left_ff        <= left_ff - 8'h01;
      seq_cycle_done <= (left_ff == 8'h01);
    end
  end
  // current and valves only while running; cycle data inverted off the pulse
  assign seq_inv_cmd = (left_ff != 8'h00);
  assign seq_valve   = seq_inv_cmd ? (left_ff[3:0] | 4'h1) : 4'h0;
  assign seq_programming_position    = seq_cycle_done ? cyc_programming_position : ~cyc_programming_position;
  assign seq_tool    = seq_cycle_done ? cyc_tool : ~cyc_tool;
  assign seq_programming_position_id = seq_cycle_done ? cyc_id : ~cyc_id;
endmodule

//--- hw/wpc_panel_ctrl.sv
// front-panel cycle control: start source, weld mode, restart, spot counters
// assumes keys and pins are asynchronous, sequencer signals share clk
`timescale 1ns/1ps
module wpc_panel_ctrl #(
  parameter int unsigned HAND_WIN = wpc_pkg::HAND_WIN_CYC,
  parameter int unsigned CNT_W    = 26
) (
  input  wire logic                                 clk,
  input  wire logic                                 reset_n,
  input  wire logic [wpc_pkg::NUM_PINS-1:0]         pins_in,
  input  wire logic                                 seq_cycle_done,
  input  wire logic [8:0]                           seq_programming_position,
  input  wire logic [1:0]                           seq_tool,
  input  wire logic [8*wpc_pkg::ID_CHARS-1:0]       seq_programming_position_id,
  input  wire logic                                 seq_error,
  input  wire logic                                 seq_inv_cmd,
  input  wire logic [3:0]                           seq_valve,
  input  wire logic [7:0]                           reg_addr,
  input  wire logic [31:0]                          reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output logic      [31:0]                          reg_rdata,
  output logic                                      start_req,
  output logic                                      inv_cmd_out,
  output logic      [3:0]                           valve_out,
  output logic                                      aux_supply_output,
  output logic                                      cap_charge_out,
  output logic                                      keypad_en,
  output logic                                      led_dual_button_start,
  output logic                                      led_weld,
  output logic                                      led_start1,
  output logic                                      led_start2,
  output logic                                      led_press_stop,
  output logic                                      led_inv,
  output logic      [3:0]                           led_valve,
  output logic                                      status_update
);
  localparam logic [CNT_W-1:0] WIN = CNT_W'(HAND_WIN);

  logic [wpc_pkg::NUM_PINS-1:0] sy1_ff, sy2_ff, sy3_ff, pin_ff, pin_prev_ff;
  logic [wpc_pkg::NUM_PINS-1:0] rise;
  logic                         enabled_ff, weld_mode_ff, src_ff, err_ff, cyc_weld_ff;
  logic                         armed_ff, start_ff, upd_ff;
  logic [CNT_W-1:0]             win_cnt_ff;
  logic [2:0]                   tools_ff, tgt_ff;
  logic [15:0]                  spot_ff [wpc_pkg::NUM_TOOLS];
  logic [8:0]                   last_programming_position_ff;
  logic [1:0]                   last_tool_ff;
  logic [8*wpc_pkg::ID_CHARS-1:0] last_id_ff;
  logic [31:0]                  rdata_ff;
  wpc_pkg::wpc_menu_e           menu_ff;
  logic                         both, one, start_ok, start_two, start_ped, menu_on;
  logic                         zero_go, inc_go;

  // next clear target, cycling through enabled tools and all
  function automatic logic [2:0] nxt_tgt(input logic [2:0] cur, input logic [2:0] n, input logic up);
    logic [2:0] r;
    r = cur;
    if (up) begin
      r = (cur == wpc_pkg::TGT_ALL) ? 3'h0 : ((cur + 3'h1 >= n) ? wpc_pkg::TGT_ALL : cur + 3'h1);
    end else begin
      r = (cur == wpc_pkg::TGT_ALL) ? n - 3'h1 : ((cur == 3'h0) ? wpc_pkg::TGT_ALL : cur - 3'h1);
    end
    return r;
  endfunction

  // three-stage synchroniser, change accepted when stages two and three agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sy1_ff      <= '0;
      sy2_ff      <= '0;
      sy3_ff      <= '0;
      pin_ff      <= '0;
      pin_prev_ff <= '0;
    end else begin
      sy1_ff      <= pins_in;
      sy2_ff      <= sy1_ff;
      sy3_ff      <= sy2_ff;
      pin_ff      <= (sy2_ff & sy3_ff) | (pin_ff & (sy2_ff | sy3_ff));
      pin_prev_ff <= pin_ff;
    end
  end

  assign rise    = pin_ff & ~pin_prev_ff;
  assign menu_on = (menu_ff == wpc_pkg::ST_CLR_MENU);

  // restart enable, latched until reset_n is asserted
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enabled_ff <= 1'b0;
    end else if (rise[wpc_pkg::PIN_RESTART]) begin
      enabled_ff <= 1'b1;
    end
  end

  // start source and weld mode toggles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      src_ff       <= wpc_pkg::SRC_RST;
      weld_mode_ff <= wpc_pkg::WELD_MODE_RST;
    end else if (enabled_ff) begin
      if (rise[wpc_pkg::PIN_SRC_KEY]) begin
        src_ff <= ~src_ff;
      end
      if (rise[wpc_pkg::PIN_WELD_KEY]) begin
        weld_mode_ff <= ~weld_mode_ff;
      end
    end
  end

  // two-hand pairing window
  assign both = pin_ff[wpc_pkg::PIN_HAND_A] & pin_ff[wpc_pkg::PIN_HAND_B];
  assign one  = pin_ff[wpc_pkg::PIN_HAND_A] ^ pin_ff[wpc_pkg::PIN_HAND_B];
  assign start_two = armed_ff & both & ~(pin_prev_ff[wpc_pkg::PIN_HAND_A] & pin_prev_ff[wpc_pkg::PIN_HAND_B])
                   & (win_cnt_ff < WIN);
  assign start_ped = rise[wpc_pkg::PIN_PEDAL];
  assign start_ok  = enabled_ff & ~pin_ff[wpc_pkg::PIN_PROGRAMMING_POSITION] & ~err_ff & ~menu_on;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      win_cnt_ff <= '0;
      armed_ff   <= 1'b1;
    end else begin
      if (!one) begin
        win_cnt_ff <= '0;
      end else if (win_cnt_ff < WIN) begin
        win_cnt_ff <= win_cnt_ff + CNT_W'(1);
      end
      if (!pin_ff[wpc_pkg::PIN_HAND_A] && !pin_ff[wpc_pkg::PIN_HAND_B]) begin
        armed_ff <= 1'b1;
      end else if (both) begin
        armed_ff <= 1'b0;
      end
    end
  end

  // start pulse from the selected source only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      start_ff    <= 1'b0;
      cyc_weld_ff <= 1'b0;
    end else begin
      start_ff <= start_ok & (src_ff ? start_two : start_ped);
      if (start_ff) begin
        cyc_weld_ff <= weld_mode_ff;
      end
    end
  end
  assign start_req = start_ff;

  // error latch, a new error wins over the clear key
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err_ff <= 1'b0;
    end else if (seq_error) begin
      err_ff <= 1'b1;
    end else if (rise[wpc_pkg::PIN_CLEAR]) begin
      err_ff <= 1'b0;
    end
  end

  // counter clear menu
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      menu_ff <= wpc_pkg::ST_IDLE;
      tgt_ff  <= 3'h0;
    end else begin
      case (menu_ff)
        wpc_pkg::ST_IDLE: begin
          if (rise[wpc_pkg::PIN_CLEAR] && enabled_ff) begin
            menu_ff <= wpc_pkg::ST_CLR_MENU;
            tgt_ff  <= 3'h0;
          end
        end
        wpc_pkg::ST_CLR_MENU: begin
          if (rise[wpc_pkg::PIN_PLUS] || rise[wpc_pkg::PIN_MINUS]) begin
            menu_ff <= wpc_pkg::ST_IDLE;
          end else if (rise[wpc_pkg::PIN_UP]) begin
            tgt_ff <= nxt_tgt(tgt_ff, tools_ff, 1'b1);
          end else if (rise[wpc_pkg::PIN_DOWN]) begin
            tgt_ff <= nxt_tgt(tgt_ff, tools_ff, 1'b0);
          end
        end
        default: menu_ff <= wpc_pkg::ST_IDLE;
      endcase
    end
  end

  // spot counters per tool, weld cycles only, saturating
  assign zero_go = menu_on & rise[wpc_pkg::PIN_PLUS];
  assign inc_go  = seq_cycle_done & cyc_weld_ff & ({1'b0, seq_tool} < tools_ff);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < wpc_pkg::NUM_TOOLS; i++) begin
        spot_ff[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < wpc_pkg::NUM_TOOLS; i++) begin
        if (inc_go && seq_tool == 2'(i)) begin
          if (spot_ff[i] < wpc_pkg::SPOT_MAX) begin
            spot_ff[i] <= spot_ff[i] + 16'h0001;
          end
        end else if (zero_go && (tgt_ff == wpc_pkg::TGT_ALL || tgt_ff == 3'(i))) begin
          spot_ff[i] <= 16'h0000;
        end
      end
    end
  end

  // last-weld report, refreshed after every completed cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      upd_ff       <= 1'b0;
      last_programming_position_ff <= wpc_pkg::PROGRAMMING_POSITION_MIN;
      last_tool_ff <= 2'h0;
      last_id_ff   <= '0;
    end else begin
      upd_ff <= seq_cycle_done;
      if (seq_cycle_done) begin
        if (seq_programming_position >= wpc_pkg::PROGRAMMING_POSITION_MIN && seq_programming_position <= wpc_pkg::PROGRAMMING_POSITION_MAX) begin
          last_programming_position_ff <= seq_programming_position;
        end
        last_tool_ff <= seq_tool;
        last_id_ff   <= seq_programming_position_id;
      end
    end
  end
  assign status_update = upd_ff;

  // configuration register and read port
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tools_ff <= wpc_pkg::TOOLS_RST;
    end else if (reg_wr && reg_addr == wpc_pkg::REG_CFG && reg_wdata[2:0] >= 3'h1 && reg_wdata[2:0] <= 3'h4) begin
      tools_ff <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        wpc_pkg::REG_CFG:    rdata_ff <= {29'h0, tools_ff};
        wpc_pkg::REG_STATUS: rdata_ff <= {22'h0, tgt_ff, menu_on, err_ff, weld_mode_ff, src_ff,
                                          enabled_ff, pin_ff[wpc_pkg::PIN_PROGRAMMING_POSITION], cyc_weld_ff};
        wpc_pkg::REG_LAST:   rdata_ff <= {20'h0, last_tool_ff == 2'h3, last_tool_ff, last_programming_position_ff};
        wpc_pkg::REG_ID_LO:  rdata_ff <= last_id_ff[31:0];
        wpc_pkg::REG_ID_HI:  rdata_ff <= last_id_ff[63:32];
        wpc_pkg::REG_COUNT0: rdata_ff <= {16'h0, spot_ff[0]};
        8'h18:               rdata_ff <= {16'h0, spot_ff[1]};
        8'h1c:               rdata_ff <= {16'h0, spot_ff[2]};
        8'h20:               rdata_ff <= {16'h0, spot_ff[3]};
        default:             rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_ff;

  // outputs and indicators; current gated by restart and weld mode, valves and supplies by restart, pin indicators ungated
  assign inv_cmd_out           = seq_inv_cmd & enabled_ff & weld_mode_ff;
  assign led_inv               = inv_cmd_out;
  assign valve_out             = enabled_ff ? seq_valve : 4'h0;
  assign led_valve             = valve_out;
  assign aux_supply_output     = enabled_ff;
  assign cap_charge_out        = enabled_ff;
  assign keypad_en             = enabled_ff & pin_ff[wpc_pkg::PIN_PROGRAMMING_POSITION];
  assign led_dual_button_start = src_ff;
  assign led_weld              = weld_mode_ff;
  assign led_start1            = pin_ff[wpc_pkg::PIN_HAND_A];
  assign led_start2            = pin_ff[wpc_pkg::PIN_HAND_B];
  assign led_press_stop        = pin_ff[wpc_pkg::PIN_AUX_INPUT_ONE] & pin_ff[wpc_pkg::PIN_AUX_INPUT_TWO];

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_NO_START_BEFORE_RESTART: assert property (!enabled_ff |-> ##1 !start_req)
    else $error("start issued before restart");
  AST_NO_CURRENT_INHIBIT: assert property (!weld_mode_ff |-> !inv_cmd_out)
    else $error("current commanded in inhibit mode");
  AST_INV_LED: assert property (led_inv == (seq_inv_cmd && enabled_ff && weld_mode_ff))
    else $error("inverter indicator mismatch");
  AST_AUX_AFTER_RESTART: assert property (rise[wpc_pkg::PIN_RESTART] |=> aux_supply_output && cap_charge_out)
    else $error("aux supply not on after restart");
  AST_PEDAL_ONLY: assert property (start_req && !$past(src_ff) |-> $past(start_ped))
    else $error("start not from pedal");
  AST_TWO_HAND_WINDOW: assert property (start_req && $past(src_ff) |-> $past(win_cnt_ff) < WIN)
    else $error("two-hand start outside window");
  AST_NO_START_PROGRAMMING_POSITION: assert property (pin_ff[wpc_pkg::PIN_PROGRAMMING_POSITION] |=> !start_req)
    else $error("start in programming position");
  AST_COUNT_MAX: assert property (spot_ff[0] <= wpc_pkg::SPOT_MAX && spot_ff[3] <= wpc_pkg::SPOT_MAX)
    else $error("spot counter above maximum");
  AST_NOWELD_NO_COUNT: assert property (seq_cycle_done && !cyc_weld_ff && !zero_go |=> $stable(spot_ff[0]))
    else $error("counter moved in inhibit mode");
  AST_INC_ONE: assert property (inc_go && seq_tool == 2'h0 && spot_ff[0] < wpc_pkg::SPOT_MAX
                                |=> spot_ff[0] == $past(spot_ff[0]) + 16'h0001)
    else $error("counter did not advance by one");
  AST_MINUS_KEEPS: assert property (menu_on && rise[wpc_pkg::PIN_MINUS] && !inc_go |=> $stable(spot_ff[1]) && !menu_on)
    else $error("cancel changed counters");
  AST_STATUS_UPD: assert property (seq_cycle_done |=> status_update ##1 !status_update || seq_cycle_done)
    else $error("status update missing");
  AST_PROGRAMMING_POSITION_RANGE: assert property (last_programming_position_ff >= wpc_pkg::PROGRAMMING_POSITION_MIN && last_programming_position_ff <= wpc_pkg::PROGRAMMING_POSITION_MAX)
    else $error("reported program out of range");
  COV_PEDAL_START: cover property (start_req && !src_ff);
  COV_TWO_HAND: cover property (start_req && src_ff);
  COV_CLEAR_ALL: cover property (zero_go && tgt_ff == wpc_pkg::TGT_ALL);
endmodule

//--- pkg/wpc_pkg.sv
// package of constants for the weld panel cycle control block
// assumes a 100 MHz clock and a plain register port behind the panel
package wpc_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned HAND_WIN_NS   = 500000000;
  localparam int unsigned HAND_WIN_CYC  = HAND_WIN_NS / CLK_PERIOD_NS;
  // counter and report ranges
  localparam logic [15:0] SPOT_MAX  = 16'hfde8;
  localparam logic [8:0]  PROGRAMMING_POSITION_MIN  = 9'h001;
  localparam logic [8:0]  PROGRAMMING_POSITION_MAX  = 9'h12c;
  localparam int unsigned NUM_TOOLS = 4;
  localparam int unsigned ID_CHARS  = 8;
  // synchronised pin positions
  localparam int unsigned PIN_RESTART = 0;
  localparam int unsigned PIN_SRC_KEY = 1;
  localparam int unsigned PIN_WELD_KEY = 2;
  localparam int unsigned PIN_CLEAR   = 3;
  localparam int unsigned PIN_UP      = 4;
  localparam int unsigned PIN_DOWN    = 5;
  localparam int unsigned PIN_PLUS    = 6;
  localparam int unsigned PIN_MINUS   = 7;
  localparam int unsigned PIN_PROGRAMMING_POSITION    = 8;
  localparam int unsigned PIN_PEDAL   = 9;
  localparam int unsigned PIN_HAND_A  = 10;
  localparam int unsigned PIN_HAND_B  = 11;
  localparam int unsigned PIN_AUX_INPUT_ONE    = 12;
  localparam int unsigned PIN_AUX_INPUT_TWO    = 13;
  localparam int unsigned NUM_PINS    = 14;
  // register offsets
  localparam logic [7:0] REG_CFG    = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LAST   = 8'h08;
  localparam logic [7:0] REG_ID_LO  = 8'h0c;
  localparam logic [7:0] REG_ID_HI  = 8'h10;
  localparam logic [7:0] REG_COUNT0 = 8'h14;
  // reset values
  localparam logic [2:0] TOOLS_RST     = 3'h4;
  localparam logic       WELD_MODE_RST = 1'b0;
  localparam logic       SRC_RST       = 1'b0;
  // clear target code for all counters
  localparam logic [2:0] TGT_ALL = 3'h4;
  typedef enum logic [0:0] {ST_IDLE, ST_CLR_MENU} wpc_menu_e;
endpackage
